// *** logic/spcr_pkg.sv ***
// package of the serial port configuration register bank
// assumes an 8-bit byte access port from the serial control engine
package spcr_pkg;

    // register offsets
    localparam logic [11:0] SPCR_OFS_CONFIG   = 12'h0000;
    localparam logic [11:0] SPCR_OFS_PART_IDENTIFIER = 12'h0003;
    localparam logic [11:0] SPCR_OFS_BANK_SEL = 12'h0004;
    localparam logic [11:0] SPCR_OFS_TAG_LOW  = 12'h0005;
    localparam logic [11:0] SPCR_OFS_TAG_HIGH = 12'h0006;

    // field positions
    localparam int SPCR_POS_SOFT_RESET = 5;
    localparam int SPCR_POS_BANK_SEL   = 0;

    // reset values
    localparam logic [7:0] SPCR_RST_TAG_LOW  = 8'h00;
    localparam logic [7:0] SPCR_RST_TAG_HIGH = 8'h00;
    localparam logic       SPCR_RST_BANK_SEL = 1'b0;
    localparam logic [7:0] SPCR_RST_BYTE     = 8'h00;

    // arbitrary neutral identifier value, not any real part's code
    localparam logic [7:0] SPCR_PART_IDENTIFIER_VALUE = 8'h5A;

    // one byte access from the serial engine
    typedef struct packed {
        logic        wrEn;
        logic        rdEn;
        logic [11:0] addr;
        logic [7:0]  wrData;
    } spcr_req_type;

    // image held in nonvolatile storage
    typedef struct packed {
        logic [7:0] tagLow;
        logic [7:0] tagHigh;
        logic       bankSel;
    } spcr_nvm_type;

endpackage

// *** logic/spcr_regs.sv ***
// serial port configuration register bank for I2C mode
// assumes the serial engine runs on clk and issues one-cycle byte requests
`timescale 1ns/1ps
`default_nettype none

module spcr_regs
    import spcr_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire spcr_req_type req,
    input  wire logic         ioUpdate,
    input  wire logic         nvmLoadStrap,
    input  wire spcr_nvm_type nvmImage,
    output logic [7:0]        rdData,
    output logic              rdValid,
    output logic [15:0]       userTag,
    output logic              reloadPulse
);

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic [7:0] tagLowBuf;
        logic [7:0] tagHighBuf;
        logic [7:0] tagLowAct;
        logic [7:0] tagHighAct;
        logic       bankSelBuf;
        logic       bankSelAct;
        logic       softRst;
        logic       reload;
        logic [7:0] rdData;
        logic       rdValid;
        logic       strapMeta;
        logic       strapSync;
    } spcr_state_type;

    spcr_state_type state_q;
    spcr_state_type state_d;
    logic           writeHit;
    logic           softReq;

    // ************************************************************
    // next state
    // ************************************************************
    // one process for all state; reload outranks a write in the same cycle
    always_comb begin
        state_d           = state_q;
        state_d.reload    = 1'b0;
        state_d.rdValid   = req.rdEn;
        state_d.strapMeta = nvmLoadStrap;
        state_d.strapSync = state_q.strapMeta;
        writeHit          = req.wrEn;
        softReq           = req.wrEn && req.addr == SPCR_OFS_CONFIG
                            && req.wrData[SPCR_POS_SOFT_RESET];

        // readback mux, unused bits stay zero
        state_d.rdData = SPCR_RST_BYTE;
        if (req.rdEn) begin
            unique case (req.addr)
                SPCR_OFS_CONFIG:
                    state_d.rdData[SPCR_POS_SOFT_RESET] = state_q.softRst;
                SPCR_OFS_PART_IDENTIFIER:
                    state_d.rdData = SPCR_PART_IDENTIFIER_VALUE;
                SPCR_OFS_BANK_SEL:
                    state_d.rdData[SPCR_POS_BANK_SEL] =
                        state_q.bankSelAct ? state_q.bankSelAct
                                           : state_q.bankSelBuf;
                SPCR_OFS_TAG_LOW:
                    state_d.rdData = state_q.bankSelAct ? state_q.tagLowAct
                                     : state_q.tagLowBuf;
                SPCR_OFS_TAG_HIGH:
                    state_d.rdData = state_q.bankSelAct ? state_q.tagHighAct
                                     : state_q.tagHighBuf;
                default:
                    state_d.rdData = SPCR_RST_BYTE;
            endcase
        end

        // buffer to active on update; bank select acts at once so that
        // software can always switch the readback view back
        if (ioUpdate) begin
            state_d.tagLowAct  = state_q.tagLowBuf;
            state_d.tagHighAct = state_q.tagHighBuf;
        end

        // writes; bits 7:6 and 4:0 of config are dropped, so the order
        // bit has no effect in this mode
        if (writeHit) begin
            unique case (req.addr)
                SPCR_OFS_CONFIG:
                    if (req.wrData[SPCR_POS_SOFT_RESET])
                        state_d.softRst = 1'b1;
                SPCR_OFS_BANK_SEL: begin
                    state_d.bankSelBuf = req.wrData[SPCR_POS_BANK_SEL];
                    state_d.bankSelAct = req.wrData[SPCR_POS_BANK_SEL];
                end
                SPCR_OFS_TAG_LOW:
                    state_d.tagLowBuf = req.wrData;
                SPCR_OFS_TAG_HIGH:
                    state_d.tagHighBuf = req.wrData;
                default: ; // identifier and holes ignore writes
            endcase
        end

        // soft reset: one cycle after the request, pick the source by strap
        if (state_q.softRst) begin
            // a new request in the clearing cycle wins over the self-clear
            state_d.softRst = softReq;
            state_d.reload  = 1'b1;
            if (state_q.strapSync) begin
                state_d.tagLowBuf  = nvmImage.tagLow;
                state_d.tagHighBuf = nvmImage.tagHigh;
                state_d.bankSelBuf = nvmImage.bankSel;
            end else begin
                state_d.tagLowBuf  = SPCR_RST_TAG_LOW;
                state_d.tagHighBuf = SPCR_RST_TAG_HIGH;
                state_d.bankSelBuf = SPCR_RST_BANK_SEL;
            end
            state_d.tagLowAct  = state_d.tagLowBuf;
            state_d.tagHighAct = state_d.tagHighBuf;
            state_d.bankSelAct = state_d.bankSelBuf;
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    // synchronous reset to defaults
    always_ff @(posedge clk) begin
        if (!rstn) begin
            state_q            <= '0;
            state_q.tagLowBuf  <= SPCR_RST_TAG_LOW;
            state_q.tagHighBuf <= SPCR_RST_TAG_HIGH;
            state_q.tagLowAct  <= SPCR_RST_TAG_LOW;
            state_q.tagHighAct <= SPCR_RST_TAG_HIGH;
            state_q.bankSelBuf <= SPCR_RST_BANK_SEL;
            state_q.bankSelAct <= SPCR_RST_BANK_SEL;
        end else begin
            state_q <= state_d;
        end
    end

    // outputs straight from flops; the active tag also feeds the readback mux
    assign rdData      = state_q.rdData;
    assign rdValid     = state_q.rdValid;
    assign userTag     = {state_q.tagHighAct, state_q.tagLowAct};
    assign reloadPulse = state_q.reload;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence softWrite;
        req.wrEn && req.addr == SPCR_OFS_CONFIG
            && req.wrData[SPCR_POS_SOFT_RESET];
    endsequence

    sequence selfClear;
        state_q.softRst ##1 reloadPulse;
    endsequence

    a_soft_self_clear: assert property (softWrite |=> selfClear)
        else $error("soft reset bit did not self-clear with reload");
    // a request landing while the bit clears re-arms it, else it drops
    a_soft_clears: assert property (
        state_q.softRst |=> state_q.softRst == $past(softReq))
        else $error("soft reset bit clear or re-arm wrong");
    a_strap_high_load: assert property (
        state_q.softRst && state_q.strapSync |=>
        state_q.tagLowBuf == $past(nvmImage.tagLow)
        && state_q.tagHighAct == $past(nvmImage.tagHigh))
        else $error("strap high soft reset missed storage image");
    a_strap_low_default: assert property (
        state_q.softRst && !state_q.strapSync |=>
        userTag == 16'h0000 && state_q.bankSelBuf == SPCR_RST_BANK_SEL)
        else $error("strap low soft reset missed defaults");
    a_ident_read: assert property (
        req.rdEn && req.addr == SPCR_OFS_PART_IDENTIFIER |=>
        rdValid && rdData == SPCR_PART_IDENTIFIER_VALUE)
        else $error("identifier read wrong");
    a_bank_view: assert property (
        req.rdEn && req.addr == SPCR_OFS_TAG_LOW && !state_q.bankSelAct |=>
        rdData == $past(state_q.tagLowBuf))
        else $error("buffer bank not returned");
    a_active_view: assert property (
        req.rdEn && req.addr == SPCR_OFS_TAG_LOW && state_q.bankSelAct |=>
        rdData == $past(state_q.tagLowAct))
        else $error("active bank not returned");
    a_tag_write: assert property (
        req.wrEn && req.addr == SPCR_OFS_TAG_HIGH && !state_q.softRst |=>
        state_q.tagHighBuf == $past(req.wrData))
        else $error("tag high write lost");
    a_tag_isolated: assert property (
        req.wrEn && req.addr == SPCR_OFS_TAG_LOW && !state_q.softRst
        && !req.rdEn |=> !reloadPulse && $stable(state_q.bankSelAct))
        else $error("tag write disturbed other state");
    // only the pending soft reset bit may ever show in a config read
    a_order_ignored: assert property (
        req.rdEn && req.addr == SPCR_OFS_CONFIG |=>
        rdData[7:6] == 2'h0 && rdData[4:0] == 5'h00
        && rdData[SPCR_POS_SOFT_RESET] == $past(state_q.softRst))
        else $error("config readback shows more than the pending bit");
    a_unused_zero: assert property (
        req.rdEn && req.addr == SPCR_OFS_BANK_SEL |=>
        rdData[7:1] == 7'h00)
        else $error("unused bits not zero");

endmodule

`default_nettype wire

// *** test/spcr_host_model.sv ***
// host model: issues byte requests to the register bank
// assumes the bank takes a request at the rising edge of clk
`timescale 1ns/1ps
`default_nettype none
module spcr_host_model
    import spcr_pkg::*;
(
    input  wire logic [7:0] rdData,
    input  wire logic       rdValid,
    input  wire logic       clk,
    output var spcr_req_type req
);
    // ****
    // byte access tasks
    // ****
    initial req = '{1'b0, 1'b0, 12'h0000, 8'h00};
    // released lines flip so stale values never look live
    task automatic idle();
        req.wrEn   <= 1'b0;
        req.rdEn   <= 1'b0;
        req.addr   <= ~req.addr;
        req.wrData <= ~req.wrData;
    endtask
    // config writes carry the bit-reversed nibble
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [7:0] v;
        v = d;
        if (a == SPCR_OFS_CONFIG) begin
            v[3:0] = {d[4], d[5], d[6], d[7]};
        end
        @(posedge clk);
        req <= '{1'b1, 1'b0, a, v};
        @(posedge clk);
        idle();
    endtask
    // read data is taken once the edge after the request has landed
    task automatic rd(input logic [11:0] a, output logic [7:0] d,
                      output logic vld);
        @(posedge clk);
        req <= '{1'b0, 1'b1, a, ~req.wrData};
        @(posedge clk);
        idle();
        #1;
        d   = rdData;
        vld = rdValid;
    endtask
endmodule
`default_nettype wire

// *** test/tb_serial_port_config_regs.sv ***
// testbench of the configuration register bank
// assumes one 100 MHz clock and the host model for all accesses
`timescale 1ns/1ps
`default_nettype none
module tb_serial_port_config_regs import spcr_pkg::*;;
    logic         clk = 1'b0;
    logic         rstn, ioUpdate, nvmLoadStrap, rdValid, reloadPulse;
    spcr_nvm_type nvmImage;
    spcr_req_type req;
    logic [7:0]   rdData;
    logic [15:0]  userTag;
    int           miscompares = 0;
    int           checksDone = 0;
    spcr_regs spcr_regs_i (.clk(clk), .rstn(rstn), .req(req),
        .ioUpdate(ioUpdate), .nvmLoadStrap(nvmLoadStrap),
        .nvmImage(nvmImage), .rdData(rdData), .rdValid(rdValid),
        .userTag(userTag), .reloadPulse(reloadPulse));
    spcr_host_model spcr_host_model_i (.clk(clk), .rdData(rdData),
        .rdValid(rdValid), .req(req));
    always #5 clk = ~clk;
    // ****
    // compare tasks
    // ****
    task automatic chk8(input string n, input logic [7:0] e, g);
        checksDone++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk16(input string n, input logic [15:0] e, g);
        checksDone++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rdc(input logic [11:0] a, input logic [7:0] e);
        logic [7:0] d;
        logic       v;
        spcr_host_model_i.rd(a, d, v);
        chk8("rdValid", 8'h01, {7'h00, v});
        chk8("rdData", e, d);
    endtask
    // reload must show within a few cycles of the soft reset write
    task automatic waitReload();
        logic seen;
        seen = 1'b0;
        repeat (4) begin
            @(posedge clk);
            #1;
            if (reloadPulse === 1'b1) seen = 1'b1;
        end
        chk8("reloadPulse", 8'h01, {7'h00, seen});
    endtask
    task automatic wrapUp();
        $display("checks %0d miscompares %0d", checksDone, miscompares);
        if (miscompares == 0 && checksDone > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        #100000;
        miscompares++;
        wrapUp();
    end
    // ****
    // test sequence
    // ****
    initial begin
        rstn = 1'b0;
        ioUpdate = 1'b0;
        nvmLoadStrap = 1'b1;
        nvmImage = '{8'h77, 8'h88, 1'b1};
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk16("userTag", 16'h0000, userTag);
        rdc(SPCR_OFS_TAG_LOW, 8'h00);
        rdc(SPCR_OFS_TAG_HIGH, 8'h00);
        rdc(SPCR_OFS_BANK_SEL, 8'h00);
        spcr_host_model_i.wr(SPCR_OFS_PART_IDENTIFIER, 8'hFF);
        rdc(SPCR_OFS_PART_IDENTIFIER, SPCR_PART_IDENTIFIER_VALUE);
        spcr_host_model_i.wr(SPCR_OFS_BANK_SEL, 8'hFE);
        rdc(SPCR_OFS_BANK_SEL, 8'h00);
        rdc(12'h0001, 8'h00);
        spcr_host_model_i.wr(SPCR_OFS_CONFIG, 8'hC0);
        rdc(SPCR_OFS_CONFIG, 8'h00);
        spcr_host_model_i.wr(SPCR_OFS_TAG_LOW, 8'h3C);
        spcr_host_model_i.wr(SPCR_OFS_TAG_HIGH, 8'hA5);
        rdc(SPCR_OFS_TAG_LOW, 8'h3C);
        rdc(SPCR_OFS_TAG_HIGH, 8'hA5);
        rdc(SPCR_OFS_PART_IDENTIFIER, SPCR_PART_IDENTIFIER_VALUE);
        chk16("userTag", 16'h0000, userTag);
        @(posedge clk);
        ioUpdate <= 1'b1;
        @(posedge clk);
        ioUpdate <= 1'b0;
        #1;
        chk16("userTag", 16'hA53C, userTag);
        spcr_host_model_i.wr(SPCR_OFS_TAG_LOW, 8'h11);
        spcr_host_model_i.wr(SPCR_OFS_BANK_SEL, 8'h01);
        rdc(SPCR_OFS_TAG_LOW, 8'h3C);
        spcr_host_model_i.wr(SPCR_OFS_CONFIG, 8'h20);
        waitReload();
        chk16("userTag", 16'h8877, userTag);
        rdc(SPCR_OFS_BANK_SEL, 8'h01);
        rdc(SPCR_OFS_TAG_LOW, 8'h77);
        rdc(SPCR_OFS_CONFIG, 8'h00);
        @(posedge clk);
        nvmLoadStrap <= 1'b0;
        repeat (3) @(posedge clk);
        spcr_host_model_i.wr(SPCR_OFS_CONFIG, 8'h20);
        waitReload();
        chk16("userTag", 16'h0000, userTag);
        rdc(SPCR_OFS_BANK_SEL, 8'h00);
        rdc(SPCR_OFS_TAG_HIGH, 8'h00);
        wrapUp();
    end
endmodule
`default_nettype wire
